// *** logic/gpio_map.vh ***
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// register offsets on the local register port
`define OFS_FIRST_PINS 4'h0
`define OFS_FIRST_LATCH 4'h1
`define OFS_FIRST_DIR 4'h2
`define OFS_SECOND_PINS 4'h3
`define OFS_SECOND_LATCH 4'h4
`define OFS_SECOND_DIR 4'h5
`define OFS_THIRD_PINS 4'h6
`define OFS_THIRD_LATCH 4'h7
`define OFS_THIRD_DIR 4'h8
`define OFS_SLAVE_CTRL 4'h9
`define OFS_CONV_CONFIG 4'hA

// reset values
`define DIR_RESET 8'hFF
`define SLAVE_CTRL_RESET 8'h00
`define CONV_CONFIG_RESET 8'h80
`define ZERO8 8'h00
`define ONES8 8'hFF

// slave_port_control fields
`define BIT_IN_FULL 7
`define BIT_OUT_FULL 6
`define BIT_IN_OVF 5
`define BIT_SLAVE_MODE 4

// shared pin positions on the second port
`define PIN_SLAVE_RD 0
`define PIN_SLAVE_WR 1
`define PIN_SLAVE_CS 2
`define PIN_CC2 7

// comparator output pins on the third port
`define PIN_CMP2_OUT 1
`define PIN_CMP1_OUT 2

`endif

// *** logic/pin_sync.v ***
`timescale 1ns/1ps

module pin_sync (
    input wire clk, // system clock
    input wire rst_n, // synchronous reset, active low
    input wire [7:0] pad_in, // raw pin levels
    output reg [7:0] sync_out // pin levels after two flops
);

`include "gpio_map.vh"

reg [7:0] meta;

// meta is read by sync_out alone
always @(posedge clk) begin
    if (!rst_n) begin
        meta <= `ZERO8;
        sync_out <= `ZERO8;
    end else begin
        meta <= pad_in;
        sync_out <= meta;
    end
end

endmodule

// *** logic/port_bank.v ***
`timescale 1ns/1ps

module port_bank (
    input wire clk, // system clock
    input wire rst_n, // synchronous reset, active low
    input wire latch_we, // write output latch
    input wire dir_we, // write direction register
    input wire [7:0] wdata, // write data
    input wire [7:0] ovr_en, // per-pin peripheral ownership
    input wire [7:0] ovr_oe, // peripheral drive enable
    input wire [7:0] ovr_out, // peripheral drive level
    output reg [7:0] pad_out, // registered pin level
    output reg [7:0] pad_oe, // registered drive enable
    output reg [7:0] latch, // output latch
    output reg [7:0] dir // direction, one means input
);

`include "gpio_map.vh"

reg [7:0] next_oe;
reg [7:0] next_out;
integer i;

// latch keeps its value through reset, so no reset term here
always @(posedge clk) begin
    if (latch_we) begin
        latch <= wdata;
    end
end

always @(posedge clk) begin
    if (!rst_n) begin
        dir <= `DIR_RESET;
    end else if (dir_we) begin
        dir <= wdata;
    end
end

// override never touches dir, so rmw of dir stays safe
always @* begin
    next_oe = `ZERO8;
    next_out = `ZERO8;
    for (i = 0; i < 8; i = i + 1) begin
        if (ovr_en[i]) begin
            next_oe[i] = ovr_oe[i];
            next_out[i] = ovr_out[i];
        end else begin
            next_oe[i] = ~dir[i];
            next_out[i] = latch[i];
        end
    end
end

always @(posedge clk) begin
    if (!rst_n) begin
        pad_oe <= `ZERO8;
        pad_out <= `ZERO8;
    end else begin
        pad_oe <= next_oe;
        pad_out <= next_out;
    end
end

endmodule

// *** logic/three_bidir_io_ports.v ***
// Behaviour
// RULE1: direction one puts pin driver off
// RULE2: direction zero drives pin from latch
// RULE3: latch register reads latch, not pins
// RULE4: three ports, eight independent pins each
// RULE5: slave mode turns first port into databus
// RULE6: first port pin n is bus bit n
// RULE7: second port pins 0-2 are strobes
// RULE8: second port pin 7 shared with capture/compare
// RULE9: every reset sets directions all ones
// RULE10: latches not touched by any reset
// RULE11: pins register reads pins, writes latch
// RULE12: third port pins 0-6 read zero after reset
// RULE13: analog use of third port wins
// RULE14: software selects digital before using third port
// RULE15: pins pass two flops before reads
`timescale 1ns/1ps

module three_bidir_io_ports (
    input wire ref_clk, // 125 MHz system clock
    input wire rst_n, // synchronous reset, active low
    input wire [3:0] reg_addr, // register offset
    input wire [7:0] reg_wdata, // register write data
    input wire reg_write, // write strobe
    input wire reg_read, // read strobe
    output reg [7:0] reg_rdata, // read data, cycle after strobe
    input wire [7:0] first_port_in, // first port pin levels
    output wire [7:0] first_port_out, // first port drive levels
    output wire [7:0] first_port_oe, // first port drive enables
    input wire [7:0] second_port_in, // second port pin levels
    output wire [7:0] second_port_out, // second port drive levels
    output wire [7:0] second_port_oe, // second port drive enables
    input wire [7:0] third_port_in, // third port pin levels
    output wire [7:0] third_port_out, // third port drive levels
    output wire [7:0] third_port_oe, // third port drive enables
    input wire [7:0] slave_out_data, // data the slave logic presents
    input wire slave_out_drive, // slave logic drives the bus
    input wire slave_in_full, // input buffer full flag
    input wire slave_out_full, // output buffer full flag
    input wire slave_in_ovf, // input overflow flag
    output reg slave_mode_enable, // first port in slave mode
    output reg [7:0] slave_bus_in, // synchronised bus byte
    output reg slave_read_strobe_n, // synchronised read strobe
    output reg slave_write_strobe_n, // synchronised write strobe
    output reg slave_chip_select_n, // synchronised chip select
    input wire cc2_drive, // compare unit owns second port pin 7
    input wire cc2_level, // compare output level
    output reg cc2_capture_in, // synchronised capture input
    input wire [1:0] cmp_out_en, // comparator outputs enabled
    input wire [1:0] cmp_out, // comparator output levels
    output reg [7:0] third_port_analog // analog owns pin
);

`include "gpio_map.vh"

// register state
reg [7:0] slave_port_control;
reg [7:0] converter_config;

// decoded writes
reg wr_first_latch;
reg wr_first_dir;
reg wr_second_latch;
reg wr_second_dir;
reg wr_third_latch;
reg wr_third_dir;
reg wr_slave_ctrl;
reg wr_conv_config;

// bank register copies
wire [7:0] first_latch;
wire [7:0] first_dir;
wire [7:0] second_latch;
wire [7:0] second_dir;
wire [7:0] third_latch;
wire [7:0] third_dir;

// synchronised pin levels
wire [7:0] first_sync;
wire [7:0] second_sync;
wire [7:0] third_sync;

// override controls
reg [7:0] first_ovr_en;
reg [7:0] first_ovr_oe;
reg [7:0] first_ovr_out;
reg [7:0] second_ovr_en;
reg [7:0] second_ovr_oe;
reg [7:0] second_ovr_out;
reg [7:0] third_ovr_en;
reg [7:0] third_ovr_oe;
reg [7:0] third_ovr_out;

reg [7:0] next_rdata;
wire slave_mode;
wire [7:0] third_digital;
wire [7:0] third_pins_view;
wire [7:0] slave_ctrl_view;
wire cmp1_routed;
wire cmp2_routed;

assign slave_mode = slave_port_control[`BIT_SLAVE_MODE];
assign third_digital = converter_config;

// analog pins read as zero whatever level they carry
assign third_pins_view = third_sync & third_digital; // [RULE12]

// flags and mode bit only; the low nibble reads as zero
assign slave_ctrl_view = {slave_port_control[`BIT_IN_FULL:`BIT_SLAVE_MODE], 4'h0};

// a comparator output reaches its pin only while the pin is analog
assign cmp1_routed = !third_digital[`PIN_CMP1_OUT] && cmp_out_en[0];
assign cmp2_routed = !third_digital[`PIN_CMP2_OUT] && cmp_out_en[1];

// writes to the pins register land in the latch; unmapped
// offsets write nothing
always @* begin
    wr_first_latch = 1'b0;
    wr_first_dir = 1'b0;
    wr_second_latch = 1'b0;
    wr_second_dir = 1'b0;
    wr_third_latch = 1'b0;
    wr_third_dir = 1'b0;
    wr_slave_ctrl = 1'b0;
    wr_conv_config = 1'b0;
    if (reg_write) begin
        case (reg_addr)
            `OFS_FIRST_PINS: wr_first_latch = 1'b1; // [RULE11]
            `OFS_FIRST_LATCH: wr_first_latch = 1'b1; // [RULE3]
            `OFS_FIRST_DIR: wr_first_dir = 1'b1;
            `OFS_SECOND_PINS: wr_second_latch = 1'b1; // [RULE11]
            `OFS_SECOND_LATCH: wr_second_latch = 1'b1; // [RULE3]
            `OFS_SECOND_DIR: wr_second_dir = 1'b1;
            `OFS_THIRD_PINS: wr_third_latch = 1'b1; // [RULE11]
            `OFS_THIRD_LATCH: wr_third_latch = 1'b1; // [RULE3]
            `OFS_THIRD_DIR: wr_third_dir = 1'b1;
            `OFS_SLAVE_CTRL: wr_slave_ctrl = 1'b1;
            `OFS_CONV_CONFIG: wr_conv_config = 1'b1;
            default: wr_conv_config = 1'b0;
        endcase
    end
end

// pin synchronisers
pin_sync first_sync_i (
    .clk(ref_clk),
    .rst_n(rst_n),
    .pad_in(first_port_in),
    .sync_out(first_sync) // [RULE15]
);

pin_sync second_sync_i (
    .clk(ref_clk),
    .rst_n(rst_n),
    .pad_in(second_port_in),
    .sync_out(second_sync) // [RULE15]
);

pin_sync third_sync_i (
    .clk(ref_clk),
    .rst_n(rst_n),
    .pad_in(third_port_in),
    .sync_out(third_sync) // [RULE15]
);

// first port: whole byte handed to slave logic in slave mode
always @* begin
    if (slave_mode) begin
        first_ovr_en = `ONES8; // [RULE5]
        first_ovr_oe = {8{slave_out_drive}}; // [RULE6]
        first_ovr_out = slave_out_data; // [RULE6]
    end else begin
        first_ovr_en = `ZERO8;
        first_ovr_oe = `ZERO8;
        first_ovr_out = `ZERO8;
    end
end

// second port: strobes forced to inputs, pin 7 to compare unit
always @* begin
    second_ovr_en = `ZERO8;
    second_ovr_oe = `ZERO8;
    second_ovr_out = `ZERO8;
    if (slave_mode) begin
        second_ovr_en[`PIN_SLAVE_RD] = 1'b1; // [RULE7]
        second_ovr_en[`PIN_SLAVE_WR] = 1'b1; // [RULE7]
        second_ovr_en[`PIN_SLAVE_CS] = 1'b1; // [RULE7]
    end
    if (cc2_drive) begin
        second_ovr_en[`PIN_CC2] = 1'b1; // [RULE8]
        second_ovr_oe[`PIN_CC2] = 1'b1; // [RULE8]
        second_ovr_out[`PIN_CC2] = cc2_level; // [RULE8]
    end
end

// third port: analog pins lose the digital driver, except
// where a comparator output is routed out
always @* begin
    third_ovr_en = ~third_digital; // [RULE13]
    third_ovr_oe = `ZERO8; // [RULE13]
    third_ovr_out = `ZERO8;
    if (cmp1_routed) begin
        third_ovr_oe[`PIN_CMP1_OUT] = 1'b1; // [RULE13]
        third_ovr_out[`PIN_CMP1_OUT] = cmp_out[0];
    end
    if (cmp2_routed) begin
        third_ovr_oe[`PIN_CMP2_OUT] = 1'b1; // [RULE13]
        third_ovr_out[`PIN_CMP2_OUT] = cmp_out[1];
    end
end

// each bank: per-pin direction and latch, registered drive
port_bank first_bank_i (
    .clk(ref_clk),
    .rst_n(rst_n),
    .latch_we(wr_first_latch),
    .dir_we(wr_first_dir),
    .wdata(reg_wdata),
    .ovr_en(first_ovr_en),
    .ovr_oe(first_ovr_oe),
    .ovr_out(first_ovr_out),
    .pad_out(first_port_out), // [RULE2]
    .pad_oe(first_port_oe), // [RULE1] [RULE4]
    .latch(first_latch), // [RULE10]
    .dir(first_dir) // [RULE9]
);

port_bank second_bank_i (
    .clk(ref_clk),
    .rst_n(rst_n),
    .latch_we(wr_second_latch),
    .dir_we(wr_second_dir),
    .wdata(reg_wdata),
    .ovr_en(second_ovr_en),
    .ovr_oe(second_ovr_oe),
    .ovr_out(second_ovr_out),
    .pad_out(second_port_out), // [RULE2]
    .pad_oe(second_port_oe), // [RULE1] [RULE4]
    .latch(second_latch), // [RULE10]
    .dir(second_dir) // [RULE9]
);

port_bank third_bank_i (
    .clk(ref_clk),
    .rst_n(rst_n),
    .latch_we(wr_third_latch),
    .dir_we(wr_third_dir),
    .wdata(reg_wdata),
    .ovr_en(third_ovr_en),
    .ovr_oe(third_ovr_oe),
    .ovr_out(third_ovr_out),
    .pad_out(third_port_out), // [RULE2]
    .pad_oe(third_port_oe), // [RULE1] [RULE4]
    .latch(third_latch), // [RULE10]
    .dir(third_dir) // [RULE9]
);

// only the mode bit is writable; the flags belong to the slave
// handshake logic and are copied every cycle
always @(posedge ref_clk) begin
    if (!rst_n) begin
        slave_port_control <= `SLAVE_CTRL_RESET;
    end else begin
        slave_port_control[`BIT_IN_FULL] <= slave_in_full;
        slave_port_control[`BIT_OUT_FULL] <= slave_out_full;
        slave_port_control[`BIT_IN_OVF] <= slave_in_ovf;
        if (wr_slave_ctrl) begin
            slave_port_control[`BIT_SLAVE_MODE] <= reg_wdata[`BIT_SLAVE_MODE]; // [RULE5]
        end
    end
end

// pins 0-6 start analog, so a fresh port never fights the board
always @(posedge ref_clk) begin
    if (!rst_n) begin
        converter_config <= `CONV_CONFIG_RESET; // [RULE12]
    end else if (wr_conv_config) begin
        converter_config <= reg_wdata; // [RULE14]
    end
end

// read mux; analog pins of the third port read as zero
always @* begin
    case (reg_addr)
        `OFS_FIRST_PINS: next_rdata = first_sync; // [RULE11]
        `OFS_FIRST_LATCH: next_rdata = first_latch; // [RULE3]
        `OFS_FIRST_DIR: next_rdata = first_dir;
        `OFS_SECOND_PINS: next_rdata = second_sync; // [RULE11]
        `OFS_SECOND_LATCH: next_rdata = second_latch; // [RULE3]
        `OFS_SECOND_DIR: next_rdata = second_dir;
        `OFS_THIRD_PINS: next_rdata = third_pins_view; // [RULE12] [RULE11]
        `OFS_THIRD_LATCH: next_rdata = third_latch; // [RULE3]
        `OFS_THIRD_DIR: next_rdata = third_dir;
        `OFS_SLAVE_CTRL: next_rdata = slave_ctrl_view;
        `OFS_CONV_CONFIG: next_rdata = converter_config;
        default: next_rdata = `ZERO8;
    endcase
end

// data stand only in the cycle after the read strobe
always @(posedge ref_clk) begin
    if (!rst_n) begin
        reg_rdata <= `ZERO8;
    end else if (reg_read) begin
        reg_rdata <= next_rdata;
    end else begin
        reg_rdata <= `ZERO8;
    end
end

// side outputs towards the slave, compare and analog logic;
// one extra flop of latency after the synchronisers
always @(posedge ref_clk) begin
    if (!rst_n) begin
        slave_mode_enable <= 1'b0;
        slave_bus_in <= `ZERO8;
        slave_read_strobe_n <= 1'b1;
        slave_write_strobe_n <= 1'b1;
        slave_chip_select_n <= 1'b1;
    end else begin
        slave_mode_enable <= slave_mode; // [RULE5]
        slave_bus_in <= first_sync; // [RULE6]
        slave_read_strobe_n <= second_sync[`PIN_SLAVE_RD] | ~slave_mode; // [RULE7]
        slave_write_strobe_n <= second_sync[`PIN_SLAVE_WR] | ~slave_mode; // [RULE7]
        slave_chip_select_n <= second_sync[`PIN_SLAVE_CS] | ~slave_mode; // [RULE7]
    end
end

// capture input follows the pin even while the compare unit drives it
always @(posedge ref_clk) begin
    if (!rst_n) begin
        cc2_capture_in <= 1'b0;
    end else begin
        cc2_capture_in <= second_sync[`PIN_CC2]; // [RULE8]
    end
end

always @(posedge ref_clk) begin
    if (!rst_n) begin
        third_port_analog <= ~`CONV_CONFIG_RESET;
    end else begin
        third_port_analog <= ~third_digital; // [RULE13]
    end
end

endmodule

// *** tb/pin_world.sv ***
`timescale 1ns/1ps
module pin_world (
    input wire [7:0] drv, // device level
    input wire [7:0] oe, // device enable
    input wire [7:0] ext, // outside level
    input wire [7:0] ext_oe, // outside enable
    output wire [7:0] pin // wire level
);
    // released pins go to the pull-up, never hold the last value
    assign pin = (oe & drv) | (~oe & ext_oe & ext) | (~oe & ~ext_oe);
endmodule

// *** tb/io_monitor.sv ***
`timescale 1ns/1ps
module io_monitor (
    input wire ref_clk, // clock
    input wire rst_n, // reset
    input wire [3:0] reg_addr, // offset
    input wire [7:0] reg_wdata, // wdata
    input wire reg_write, // write
    input wire reg_read, // read
    input wire [7:0] reg_rdata, // rdata
    input wire [7:0] first_port_out, // level
    input wire [7:0] first_port_oe, // enable
    input wire [7:0] second_port_out, // level
    input wire [7:0] second_port_oe, // enable
    input wire [7:0] third_port_oe, // enable
    input wire [7:0] slave_out_data, // bus data
    input wire slave_out_drive, // bus drive
    input wire slave_mode_enable, // mode
    input wire slave_read_strobe_n, // strobe
    input wire slave_write_strobe_n, // strobe
    input wire slave_chip_select_n, // select
    input wire cc2_drive, // compare owns pin
    input wire cc2_level // compare level
);
    reg [7:0] wd1;
    reg [7:0] wd2;
    // write data two edges back, when pins show the write
    always @(posedge ref_clk) begin
        wd1 <= reg_wdata;
        wd2 <= wd1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_reset_undrive: assert property (
        $rose(rst_n) |-> (first_port_oe | second_port_oe | third_port_oe) == 8'h00)
        else $error("drivers on after reset");
    a_rdata_idle: assert property (
        !reg_read |=> reg_rdata == 8'h00) else $error("read data without read");
    a_dir_to_oe: assert property (
        reg_write && reg_addr == 4'h5 |=> ##1 second_port_oe[6:3] == ~wd2[6:3])
        else $error("direction not on enables");
    a_latch_to_out: assert property (
        reg_write && (reg_addr == 4'h4 || reg_addr == 4'h3)
        |=> ##1 second_port_out[6:3] == wd2[6:3]) else $error("latch not on pins");
    a_mode_mirror: assert property (
        reg_write && reg_addr == 4'h9 |=> ##1 slave_mode_enable == wd2[4])
        else $error("mode output wrong");
    a_strobes_idle: assert property (
        !slave_mode_enable ##1 !slave_mode_enable
        |-> slave_read_strobe_n && slave_write_strobe_n && slave_chip_select_n)
        else $error("strobe active outside mode");
    a_cc2_owns: assert property (
        cc2_drive |=> second_port_oe[7] && second_port_out[7] == $past(cc2_level))
        else $error("compare output not on pin");
    a_slave_enable: assert property (
        slave_mode_enable && $past(slave_mode_enable)
        |-> first_port_oe == {8{$past(slave_out_drive)}}) else $error("bus enable wrong");
    a_slave_data: assert property (
        slave_mode_enable && $past(slave_mode_enable) && $past(slave_out_drive)
        |-> first_port_out == $past(slave_out_data)) else $error("bus data wrong");
endmodule
bind three_bidir_io_ports io_monitor mon (.*);

// *** tb/tb_three_bidir_io_ports.sv ***
`timescale 1ns/1ps
module tb_three_bidir_io_ports;
    reg ref_clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00, slave_out_data = 8'h00;
    reg slave_out_drive = 1'b0, slave_in_full = 1'b0, slave_out_full = 1'b0;
    reg slave_in_ovf = 1'b0, cc2_drive = 1'b0, cc2_level = 1'b0;
    reg [1:0] cmp_out_en = 2'h0, cmp_out = 2'h0;
    reg [7:0] ext1 = 8'h00, eoe1 = 8'h00, ext2 = 8'h00, eoe2 = 8'h00;
    reg [7:0] ext3 = 8'h00, eoe3 = 8'h00;
    wire [7:0] reg_rdata, first_port_in, first_port_out, first_port_oe;
    wire [7:0] second_port_in, second_port_out, second_port_oe, slave_bus_in;
    wire [7:0] third_port_in, third_port_out, third_port_oe, third_port_analog;
    wire slave_mode_enable, slave_read_strobe_n, slave_write_strobe_n;
    wire slave_chip_select_n, cc2_capture_in;
    integer miscompares = 0, total_checks = 0, cycles = 0;
    always #4 ref_clk = ~ref_clk;
    three_bidir_io_ports DUT (.*);
    pin_world p1 (.drv(first_port_out), .oe(first_port_oe), .ext(ext1), .ext_oe(eoe1),
        .pin(first_port_in));
    pin_world p2 (.drv(second_port_out), .oe(second_port_oe), .ext(ext2), .ext_oe(eoe2),
        .pin(second_port_in));
    pin_world p3 (.drv(third_port_out), .oe(third_port_oe), .ext(ext3), .ext_oe(eoe3),
        .pin(third_port_in));
    task test_done;
        begin
            $display("checks %0d mismatches %0d", total_checks, miscompares);
            if (miscompares == 0 && total_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            test_done;
        end
    end
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            reg_write <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge ref_clk);
            reg_write <= 1'b0;
        end
    endtask
    task rdc(input string nm, input [3:0] a, input [7:0] exp);
        begin
            @(posedge ref_clk);
            reg_read <= 1'b1;
            reg_addr <= a;
            @(posedge ref_clk);
            reg_read <= 1'b0;
            @(negedge ref_clk);
            chk(nm, reg_rdata, exp);
            @(posedge ref_clk);
        end
    endtask
    task t_reset;
        begin
            chk("oe", first_port_oe | second_port_oe | third_port_oe, 8'h00);
            rdc("dir1", 4'h2, 8'hFF);
            rdc("dir2", 4'h5, 8'hFF);
            rdc("dir3", 4'h8, 8'hFF);
            rdc("ctrl", 4'h9, 8'h00);
            eoe3 <= 8'hFF;
            ext3 <= 8'hFF;
            tick(4);
            rdc("pins3", 4'h6, 8'h80);
            $display("t_reset done");
        end
    endtask
    task t_gpio;
        begin
            wr(4'h1, 8'h5A);
            wr(4'h2, 8'h0F);
            wr(4'h4, 8'h78);
            wr(4'h5, 8'h87);
            eoe1 <= 8'h0F;
            tick(4);
            chk("oe1", first_port_oe, 8'hF0);
            chk("out1", first_port_out, 8'h5A);
            chk("oe2", second_port_oe, 8'h78);
            rdc("pins1", 4'h0, 8'h50);
            rdc("latch1", 4'h1, 8'h5A);
            wr(4'h0, 8'hC3);
            rdc("latch1", 4'h1, 8'hC3);
            $display("t_gpio done");
        end
    endtask
    task t_slave;
        begin
            slave_out_data <= 8'hA5;
            slave_out_drive <= 1'b1;
            slave_in_full <= 1'b1;
            slave_out_full <= 1'b1;
            slave_in_ovf <= 1'b1;
            wr(4'h9, 8'h10);
            tick(3);
            chk("mode", {7'h00, slave_mode_enable}, 8'h01);
            chk("oe1", first_port_oe, 8'hFF);
            chk("out1", first_port_out, 8'hA5);
            rdc("ctrl", 4'h9, 8'hF0);
            eoe2 <= 8'h07;
            ext2 <= 8'h05;
            slave_out_drive <= 1'b0;
            eoe1 <= 8'hFF;
            ext1 <= 8'h3C;
            tick(5);
            chk("strb", {5'h00, slave_chip_select_n, slave_write_strobe_n,
                slave_read_strobe_n}, 8'h05);
            chk("oe1", first_port_oe, 8'h00);
            chk("bus", slave_bus_in, 8'h3C);
            wr(4'h9, 8'h00);
            eoe1 <= 8'h0F;
            slave_in_full <= 1'b0;
            slave_out_full <= 1'b0;
            slave_in_ovf <= 1'b0;
            $display("t_slave done");
        end
    endtask
    task t_cc2;
        begin
            cc2_drive <= 1'b1;
            cc2_level <= 1'b1;
            tick(3);
            chk("cc2oe", second_port_oe & 8'h80, 8'h80);
            chk("cc2out", second_port_out & 8'h80, 8'h80);
            cc2_drive <= 1'b0;
            eoe2 <= 8'h80;
            ext2 <= 8'h00;
            tick(5);
            chk("cap", {7'h00, cc2_capture_in}, 8'h00);
            rdc("dir2", 4'h5, 8'h87);
            $display("t_cc2 done");
        end
    endtask
    task t_third;
        begin
            wr(4'h8, 8'h00);
            wr(4'h7, 8'h3C);
            eoe3 <= 8'h00;
            tick(3);
            chk("ana", third_port_analog, 8'h7F);
            chk("oe3", third_port_oe, 8'h80);
            cmp_out_en <= 2'h1;
            cmp_out <= 2'h1;
            tick(3);
            chk("cmp", third_port_oe, 8'h84);
            chk("cmpo", third_port_out & 8'h04, 8'h04);
            cmp_out_en <= 2'h0;
            wr(4'hA, 8'hFF);
            tick(3);
            chk("oe3", third_port_oe, 8'hFF);
            chk("out3", third_port_out, 8'h3C);
            $display("t_third done");
        end
    endtask
    task t_misc;
        begin
            wr(4'hB, 8'h77);
            rdc("unmap", 4'hB, 8'h00);
            wr(4'h9, 8'hEF);
            rdc("ctrl", 4'h9, 8'h00);
            rst_n <= 1'b0;
            tick(3);
            rst_n <= 1'b1;
            rdc("latch1", 4'h1, 8'hC3);
            rdc("latch3", 4'h7, 8'h3C);
            rdc("dir3", 4'h8, 8'hFF);
            $display("t_misc done");
        end
    endtask
    initial begin
        tick(3);
        rst_n <= 1'b1;
        t_reset;
        t_gpio;
        t_slave;
        t_cc2;
        t_third;
        t_misc;
        test_done;
    end
endmodule
